// ==== tmrp_defs.vh ====
// Purpose: shared constants for the dual 16/32-bit timer pair block
// Assumes: register indices are word indices; byte address is four times the index
// Notes:   timer numbering is 0 pair_a low, 1 pair_a high, 2 pair_b low, 3 pair_b high
`ifndef TMRP_DEFS_VH
`define TMRP_DEFS_VH

// register indices (byte address = index * 4)
`define TMRP_IDX_A_LCNT   10'h106
`define TMRP_IDX_A_HOLD   10'h108
`define TMRP_IDX_A_HCNT   10'h10a
`define TMRP_IDX_A_LPER   10'h10c
`define TMRP_IDX_A_HPER   10'h10e
`define TMRP_IDX_A_LCON   10'h110
`define TMRP_IDX_A_HCON   10'h112
`define TMRP_IDX_B_LCNT   10'h114
`define TMRP_IDX_B_HOLD   10'h116
`define TMRP_IDX_B_HCNT   10'h118
`define TMRP_IDX_B_LPER   10'h11a
`define TMRP_IDX_B_HPER   10'h11c
`define TMRP_IDX_B_LCON   10'h11e
`define TMRP_IDX_B_HCON   10'h120
`define TMRP_IDX_IRQ_FLAG_STATUS_0     10'h122
`define TMRP_IDX_IRQ_ENABLE_CONTROL_0     10'h124

// internal register codes returned by the address decoder
`define TMRP_C_CNT0       5'd0
`define TMRP_C_PER0       5'd4
`define TMRP_C_CON0       5'd8
`define TMRP_C_HOLD_A     5'd12
`define TMRP_C_HOLD_B     5'd13
`define TMRP_C_IRQ_FLAG_STATUS_0       5'd14
`define TMRP_C_IRQ_ENABLE_CONTROL_0       5'd15
`define TMRP_C_NONE       5'd31

// control register fields
`define TMRP_ON           15
`define TMRP_SIDL         13
`define TMRP_GATE         6
`define TMRP_PS_HI        5
`define TMRP_PS_LO        4
`define TMRP_T32          3
`define TMRP_TCS          1
`define TMRP_LCON_MASK    16'ha07a
`define TMRP_HCON_MASK    16'ha072

// interrupt flag / enable bit positions
`define TMRP_IRQ_A_BIT    7
`define TMRP_IRQ_B_BIT    8

// reset values
`define TMRP_CNT_RST      16'h0000
`define TMRP_PER_RST      16'hffff
`define TMRP_CON_RST      16'h0000
`define TMRP_PS_RST       8'h00

// prescaler terminal counts for 1:1, 1:8, 1:64, 1:256
`define TMRP_PS_DIV1      8'h00
`define TMRP_PS_DIV8      8'h07
`define TMRP_PS_DIV64     8'h3f
`define TMRP_PS_DIV256    8'hff

// bus responses
`define TMRP_RESP_OKAY    2'b00
`define TMRP_RESP_SLVERR  2'b10

`endif

// ==== tmrp_top.v ====
// Purpose: two timer pairs, each two 16-bit timers or one chained 32-bit timer,
//          with an AXI4-Lite register slave
// Assumes: aclk is the instruction clock; pins and sleep/idle are asynchronous
// Notes:   only pair_a offers a converter trigger and a time base to other blocks
//
// Overview of operation
// - pair_a upper timer pulses converter trigger on 32-bit or own 16-bit period match.
// - each timer clock passes prescaler 1, 8, 64 or 256 chosen by control bits 5:4.
// - in chained mode the lower timer's clock and prescaler drive; upper prescaler unused.
// - writes to count or control registers, and reset, clear the prescaler counter.
// - a disabled timer's prescaler is halted and is not cleared by those writes.
// - writing a control register leaves the count register unchanged.
// - during cpu sleep the timers do not count.
// - chained mode raises an event on 32-bit period match or gate falling edge.
// - that event sets the upper timer flag, bit 7 (pair_a) or bit 8 (pair_b) of flag status, and requests interrupt.
// - the interrupt is forwarded only while its enable bit 7 (pair_a) or bit 8 (pair_b) is set.
// - pair_b produces no converter trigger.
// - pair_b counts are not offered as a time base to other peripherals.
// - pair_b chained: lower timer is least significant word, upper most significant.
// - in chained mode the upper control register is ignored; lower one configures.
// - chained mode uses lower clock and gate inputs but upper flag and enable.
// - bit 3 of the lower control register selects chained mode; upper has none.
// - each pair has a 16-bit holding register for coherent 32-bit accesses.
// - chained timer counts each prescaled cycle to the combined period, then wraps to zero.
// - reading the lower count copies the upper count into the holding register.
// - in chained mode, writing lower count after the holding register loads held value into upper count.
// - gated mode counts internal clock only while gate high; steering gate's falling edge stops it and raises the flag event, except on a 16-bit lower timer.
//
// The implementer's own choice: register access over AXI4-Lite.
`include "tmrp_defs.vh"
`timescale 1ns/1ps
`default_nettype none

module tmrp_top (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [11:0] s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output reg         s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output reg         s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [11:0] s_axi_araddr,
  input  wire        s_axi_arvalid,
  output reg         s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire [3:0]  external_clock_gate_pin,
  input  wire        cpu_sleep,
  input  wire        cpu_idle,
  output reg         pair_a_irq,
  output reg         pair_b_irq,
  output reg         converter_trigger,
  output reg  [15:0] pair_a_time_base_low,
  output reg  [15:0] pair_a_time_base_high
);

  // address decoder shared by the read and write paths
  function [4:0] reg_decode;
    input [11:0] addr;
    reg   [9:0]  idx;
    begin
      idx = addr[11:2];
      if (addr[1:0] != 2'b00) reg_decode = `TMRP_C_NONE;
      else if (idx == `TMRP_IDX_A_LCNT) reg_decode = `TMRP_C_CNT0;
      else if (idx == `TMRP_IDX_A_HCNT) reg_decode = `TMRP_C_CNT0 + 5'd1;
      else if (idx == `TMRP_IDX_B_LCNT) reg_decode = `TMRP_C_CNT0 + 5'd2;
      else if (idx == `TMRP_IDX_B_HCNT) reg_decode = `TMRP_C_CNT0 + 5'd3;
      else if (idx == `TMRP_IDX_A_LPER) reg_decode = `TMRP_C_PER0;
      else if (idx == `TMRP_IDX_A_HPER) reg_decode = `TMRP_C_PER0 + 5'd1;
      else if (idx == `TMRP_IDX_B_LPER) reg_decode = `TMRP_C_PER0 + 5'd2;
      else if (idx == `TMRP_IDX_B_HPER) reg_decode = `TMRP_C_PER0 + 5'd3;
      else if (idx == `TMRP_IDX_A_LCON) reg_decode = `TMRP_C_CON0;
      else if (idx == `TMRP_IDX_A_HCON) reg_decode = `TMRP_C_CON0 + 5'd1;
      else if (idx == `TMRP_IDX_B_LCON) reg_decode = `TMRP_C_CON0 + 5'd2;
      else if (idx == `TMRP_IDX_B_HCON) reg_decode = `TMRP_C_CON0 + 5'd3;
      else if (idx == `TMRP_IDX_A_HOLD) reg_decode = `TMRP_C_HOLD_A;
      else if (idx == `TMRP_IDX_B_HOLD) reg_decode = `TMRP_C_HOLD_B;
      else if (idx == `TMRP_IDX_IRQ_FLAG_STATUS_0) reg_decode = `TMRP_C_IRQ_FLAG_STATUS_0;
      else if (idx == `TMRP_IDX_IRQ_ENABLE_CONTROL_0) reg_decode = `TMRP_C_IRQ_ENABLE_CONTROL_0;
      else reg_decode = `TMRP_C_NONE;
    end
  endfunction

  // byte-lane merge; upper lanes are not implemented
  function [15:0] merge16;
    input [15:0] old;
    input [15:0] data;
    input [1:0]  strb;
    begin
      merge16[7:0]  = strb[0] ? data[7:0] : old[7:0];
      merge16[15:8] = strb[1] ? data[15:8] : old[15:8];
    end
  endfunction

  // terminal count of the prescaler for each ratio
  function [7:0] ps_limit;
    input [1:0] sel;
    begin
      case (sel)
        2'd0:    ps_limit = `TMRP_PS_DIV1;
        2'd1:    ps_limit = `TMRP_PS_DIV8;
        2'd2:    ps_limit = `TMRP_PS_DIV64;
        default: ps_limit = `TMRP_PS_DIV256;
      endcase
    end
  endfunction

  reg  [15:0] cnt   [0:3];
  reg  [15:0] per   [0:3];
  reg  [15:0] con   [0:3];
  reg  [7:0]  pcnt  [0:3];
  reg  [15:0] hold  [0:1];
  reg         flag_a;
  reg         flag_b;
  reg         ien_a;
  reg         ien_b;
  reg  [3:0]  pin_s1;
  reg  [3:0]  pin_s2;
  reg  [3:0]  pin_d;
  reg  [1:0]  pwr_s1;
  reg  [1:0]  pwr_s2;
  reg         aw_got;
  reg         w_got;
  reg  [11:0] aw_addr;
  reg  [15:0] w_data;
  reg  [1:0]  w_strb;
  reg  [3:0]  run;
  reg  [3:0]  inclk;
  reg  [3:0]  tick;
  reg  [3:0]  gfall;
  reg  [3:0]  m16;
  reg  [1:0]  m32;
  reg  [1:0]  ev_irq;
  reg  [3:0]  pclr;
  reg  [15:0] rd_val;
  reg  [15:0] eff;
  integer     t, i;
  integer     p, j;

  wire        sleep_s = pwr_s2[0];
  wire        idle_s  = pwr_s2[1];
  wire [3:0]  pin_rise = pin_s2 & ~pin_d;
  wire [3:0]  pin_fall = ~pin_s2 & pin_d;
  wire        wr_go   = aw_got & w_got & ~s_axi_bvalid;
  wire        rd_go   = s_axi_arvalid & s_axi_arready;
  wire [4:0]  wr_code = reg_decode(aw_addr);
  wire [4:0]  rd_code = reg_decode(s_axi_araddr);
  wire [1:0]  chain   = {con[2][`TMRP_T32], con[0][`TMRP_T32]};

  // pins and power states are asynchronous: two flops before any use
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 4'h0;
      pin_s2 <= 4'h0;
      pin_d  <= 4'h0;
      pwr_s1 <= 2'h0;
      pwr_s2 <= 2'h0;
    end else begin
      pin_s1 <= external_clock_gate_pin;
      pin_s2 <= pin_s1;
      pin_d  <= pin_s2;
      pwr_s1 <= {cpu_idle, cpu_sleep};
      pwr_s2 <= pwr_s1;
    end
  end

  // per-timer clock qualification, prescaler tick and match detection
  always @* begin
    run   = 4'h0;
    inclk = 4'h0;
    tick  = 4'h0;
    gfall = 4'h0;
    m16   = 4'h0;
    m32   = 2'h0;
    pclr  = 4'h0;
    eff   = 16'h0000;
    for (t = 0; t < 4; t = t + 1) begin
      p = t / 2;
      // chained pair: lower control word steers both halves
      eff = chain[p] ? con[2 * p] : con[t];
      run[t] = eff[`TMRP_ON] & ~sleep_s & ~(idle_s & eff[`TMRP_SIDL])
               & ~(chain[p] & (t % 2 == 1));
      if (eff[`TMRP_TCS])
        inclk[t] = pin_rise[t];
      else if (eff[`TMRP_GATE])
        inclk[t] = pin_s2[t];
      else
        inclk[t] = 1'b1;
      tick[t] = run[t] & inclk[t]
                & (pcnt[t] == ps_limit(eff[`TMRP_PS_HI:`TMRP_PS_LO]));
      gfall[t] = run[t] & eff[`TMRP_GATE] & ~eff[`TMRP_TCS] & pin_fall[t];
      m16[t] = tick[t] & ~chain[p] & (cnt[t] == per[t]);
      // any count or control write of the pair clears both prescalers
      pclr[t] = wr_go & ((wr_code == `TMRP_C_CNT0 + 2 * p)
                | (wr_code == `TMRP_C_CNT0 + 2 * p + 1)
                | (wr_code == `TMRP_C_CON0 + 2 * p)
                | (wr_code == `TMRP_C_CON0 + 2 * p + 1));
    end
    for (p = 0; p < 2; p = p + 1) begin
      m32[p] = chain[p] & tick[2 * p]
               & ({cnt[2 * p + 1], cnt[2 * p]} == {per[2 * p + 1], per[2 * p]});
    end
  end

  // interrupt sources: upper flag in either mode, gate edge of the steering timer
  always @* begin
    ev_irq[0] = chain[0] ? (m32[0] | gfall[0]) : (m16[1] | gfall[1]);
    ev_irq[1] = chain[1] ? (m32[1] | gfall[2]) : (m16[3] | gfall[3]);
  end

  // read data mux
  always @* begin
    rd_val = 16'h0000;
    if (rd_code < `TMRP_C_PER0)
      rd_val = cnt[rd_code[1:0]];
    else if (rd_code < `TMRP_C_CON0)
      rd_val = per[rd_code[1:0]];
    else if (rd_code < `TMRP_C_HOLD_A)
      rd_val = con[rd_code[1:0]];
    else if (rd_code == `TMRP_C_HOLD_A)
      rd_val = hold[0];
    else if (rd_code == `TMRP_C_HOLD_B)
      rd_val = hold[1];
    else if (rd_code == `TMRP_C_IRQ_FLAG_STATUS_0) begin
      rd_val[`TMRP_IRQ_A_BIT] = flag_a;
      rd_val[`TMRP_IRQ_B_BIT] = flag_b;
    end else if (rd_code == `TMRP_C_IRQ_ENABLE_CONTROL_0) begin
      rd_val[`TMRP_IRQ_A_BIT] = ien_a;
      rd_val[`TMRP_IRQ_B_BIT] = ien_b;
    end
  end

  // timers, holding registers, flags and register writes
  always @(posedge aclk) begin
    if (!aresetn) begin
      for (i = 0; i < 4; i = i + 1) begin
        cnt[i]  <= `TMRP_CNT_RST;
        per[i]  <= `TMRP_PER_RST;
        con[i]  <= `TMRP_CON_RST;
        pcnt[i] <= `TMRP_PS_RST;
      end
      hold[0] <= `TMRP_CNT_RST;
      hold[1] <= `TMRP_CNT_RST;
      flag_a  <= 1'b0;
      flag_b  <= 1'b0;
      ien_a   <= 1'b0;
      ien_b   <= 1'b0;
    end else begin
      // prescalers: a halted prescaler ignores the clearing writes
      for (i = 0; i < 4; i = i + 1) begin
        if (pclr[i] & run[i])
          pcnt[i] <= `TMRP_PS_RST;
        else if (run[i] & inclk[i])
          pcnt[i] <= tick[i] ? `TMRP_PS_RST : pcnt[i] + 8'h01;
      end
      // counters; bus writes further down override a same-cycle count step
      for (j = 0; j < 2; j = j + 1) begin
        if (chain[j]) begin
          if (m32[j]) begin
            cnt[2 * j]     <= `TMRP_CNT_RST;
            cnt[2 * j + 1] <= `TMRP_CNT_RST;
          end else if (tick[2 * j]) begin
            // lower half is the lsw, upper half the msw
            {cnt[2 * j + 1], cnt[2 * j]} <=
              {cnt[2 * j + 1], cnt[2 * j]} + 32'h0000_0001;
          end
        end else begin
          for (i = 2 * j; i < 2 * j + 2; i = i + 1) begin
            if (m16[i])
              cnt[i] <= `TMRP_CNT_RST;
            else if (tick[i])
              cnt[i] <= cnt[i] + 16'h0001;
          end
        end
      end
      // coherent read: snapshot the msw when the lsw is read
      if (rd_go & (rd_code == `TMRP_C_CNT0))
        hold[0] <= cnt[1];
      if (rd_go & (rd_code == `TMRP_C_CNT0 + 5'd2))
        hold[1] <= cnt[3];
      if (wr_go) begin
        if (wr_code < `TMRP_C_PER0) begin
          cnt[wr_code[1:0]] <= merge16(cnt[wr_code[1:0]], w_data, w_strb);
          // lsw write of a chained pair commits the held msw
          if (wr_code == `TMRP_C_CNT0 && chain[0])
            cnt[1] <= hold[0];
          if (wr_code == `TMRP_C_CNT0 + 5'd2 && chain[1])
            cnt[3] <= hold[1];
        end else if (wr_code < `TMRP_C_CON0)
          per[wr_code[1:0]] <= merge16(per[wr_code[1:0]], w_data, w_strb);
        else if (wr_code < `TMRP_C_HOLD_A) begin
          // control write leaves counts alone; upper words have no chain bit
          con[wr_code[1:0]] <= merge16(con[wr_code[1:0]], w_data, w_strb)
                               & (wr_code[0] ? `TMRP_HCON_MASK : `TMRP_LCON_MASK);
        end else if (wr_code == `TMRP_C_HOLD_A)
          hold[0] <= merge16(hold[0], w_data, w_strb);
        else if (wr_code == `TMRP_C_HOLD_B)
          hold[1] <= merge16(hold[1], w_data, w_strb);
        else if (wr_code == `TMRP_C_IRQ_ENABLE_CONTROL_0) begin
          if (w_strb[0])
            ien_a <= w_data[`TMRP_IRQ_A_BIT];
          if (w_strb[1])
            ien_b <= w_data[`TMRP_IRQ_B_BIT];
        end
      end
      // flags: software clear, but a same-cycle event wins
      if (wr_go & (wr_code == `TMRP_C_IRQ_FLAG_STATUS_0) & w_strb[0])
        flag_a <= w_data[`TMRP_IRQ_A_BIT] | ev_irq[0];
      else if (ev_irq[0])
        flag_a <= 1'b1;
      if (wr_go & (wr_code == `TMRP_C_IRQ_FLAG_STATUS_0) & w_strb[1])
        flag_b <= w_data[`TMRP_IRQ_B_BIT] | ev_irq[1];
      else if (ev_irq[1])
        flag_b <= 1'b1;
    end
  end

  // outputs to the system, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      pair_a_irq            <= 1'b0;
      pair_b_irq            <= 1'b0;
      converter_trigger     <= 1'b0;
      pair_a_time_base_low  <= `TMRP_CNT_RST;
      pair_a_time_base_high <= `TMRP_CNT_RST;
    end else begin
      pair_a_irq <= flag_a & ien_a;
      pair_b_irq <= flag_b & ien_b;
      // only pair_a drives the trigger and the shared time base
      converter_trigger     <= chain[0] ? m32[0] : m16[1];
      pair_a_time_base_low  <= cnt[0];
      pair_a_time_base_high <= cnt[1];
    end
  end

  // write channel: address and data taken in either order, one write at a time
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `TMRP_RESP_OKAY;
      aw_got        <= 1'b0;
      w_got         <= 1'b0;
      aw_addr       <= 12'h000;
      w_data        <= 16'h0000;
      w_strb        <= 2'b00;
    end else begin
      if (s_axi_awvalid & s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        aw_got        <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_data       <= s_axi_wdata[15:0];
        w_strb       <= s_axi_wstrb[1:0];
        w_got        <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got       <= 1'b0;
        w_got        <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (wr_code == `TMRP_C_NONE) ? `TMRP_RESP_SLVERR : `TMRP_RESP_OKAY;
      end
      // ready again only after the response is taken
      if (s_axi_bvalid & s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // read channel: data registered on the same edge that takes the address
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `TMRP_RESP_OKAY;
    end else begin
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {16'h0000, rd_val};
        s_axi_rresp   <= (rd_code == `TMRP_C_NONE) ? `TMRP_RESP_SLVERR : `TMRP_RESP_OKAY;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

// ==== tmrp_top_assertions.sv ====
// Purpose: port checks on the timer pair, bus answers and timer side effects
// Assumes: one clock, synchronous active-low reset
// Notes:   bound to tmrp_top, sees only its ports
`timescale 1ns/1ps
`default_nettype none
module tmrp_chk (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        cpu_sleep,
  input wire logic        pair_a_irq,
  input wire logic        converter_trigger,
  input wire logic [15:0] pair_a_time_base_low,
  input wire logic [15:0] pair_a_time_base_high
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // handshakes that start a bus answer
  sequence s_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // sleep long enough for the synchroniser and the copy stage to settle
  sequence s_quiet_sleep;
    (cpu_sleep && !s_axi_wvalid)[*5];
  endsequence
  AST_WR_ANS: assert property (s_wr |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  AST_RD_ANS: assert property (s_rd |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  AST_B_BLOCK: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while answer pending");
  AST_RD_HI: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
    else $error("upper read half not zero");
  AST_SLEEP: assert property (s_quiet_sleep |=> $stable(pair_a_time_base_low) && $stable(pair_a_time_base_high))
    else $error("count moved in sleep");
  // a clear reaches the pin two edges after its write is taken
  AST_IRQ_KEEP: assert property (pair_a_irq && !s_axi_wvalid && !$past(s_axi_wvalid)
                                 && !$past(s_axi_wvalid, 2) |=> pair_a_irq)
    else $error("interrupt dropped without software");
  AST_TRIG_WRAP: assert property (converter_trigger |-> ##[0:3] pair_a_time_base_high == 16'h0000)
    else $error("trigger without wrap");
endmodule
bind tmrp_top tmrp_chk u_chk (.*);
`default_nettype wire

// ==== tmrp_pin_model.sv ====
// Purpose: external clock or gate pins of the timers
// Assumes: levels and enables come from the bench
// Notes:   a pin not clocking holds its commanded level, never drifts
`timescale 1ns/1ps
`default_nettype none
module tmrp_pin_model (
  input  wire logic       aclk,
  input  wire logic [3:0] clk_en,
  input  wire logic [3:0] level,
  input  wire logic [7:0] half,
  output wire logic [3:0] external_clock_gate_pin
);
  logic [7:0] cnt = 8'h00;
  logic       ph  = 1'b0;
  // square wave, half period in clock cycles
  always @(posedge aclk) begin
    cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
    if (cnt + 8'h01 >= half) begin
      ph <= ~ph;
    end
  end
  // gate level or clock per pin
  assign external_clock_gate_pin = (clk_en & {4{ph}}) | (~clk_en & level);
endmodule
`default_nettype wire

// ==== tmrp_top_test.sv ====
// Purpose: self-checking bench for the timer pair
// Assumes: bus answers checked from queues by a watcher process
// Notes:   short periods keep trigger intervals small
`timescale 1ns/1ps
`default_nettype none
`include "tmrp_defs.vh"
module tmrp_top_test;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, sleep;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, v;
  logic [3:0]  wstrb, cken, lvl;
  logic [7:0]  half;
  wire         awready, wready, bvalid, arready, rvalid, irq_a, irq_b, trig;
  wire  [1:0]  bresp, rresp;
  wire  [31:0] rdata;
  wire  [3:0]  pins;
  wire  [15:0] tb_lo, tb_hi;
  integer      error_cnt = 0, samples_checked = 0, cyc = 0, last = 0, seed = 32'h8cf5, k;
  logic [31:0] qr[$], qb[$], qt[$], qs[$];

  tmrp_top u_tmrp_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .external_clock_gate_pin(pins), .cpu_sleep(sleep), .cpu_idle(1'b0),
    .pair_a_irq(irq_a), .pair_b_irq(irq_b), .converter_trigger(trig),
    .pair_a_time_base_low(tb_lo), .pair_a_time_base_high(tb_hi));
  tmrp_pin_model u_tmrp_pin_model (.aclk(aclk), .clk_en(cken), .level(lvl), .half(half),
    .external_clock_gate_pin(pins));

  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // write: address and data offered together, each dropped when taken
  task automatic wr(input logic [9:0] i, input logic [15:0] d, input logic [1:0] r = 2'b00);
    logic a, w;
    qb.push_back({30'h0, r});
    @(posedge aclk);
    awaddr  <= {i, 2'b00};
    wdata   <= {16'h0000, d};
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(negedge aclk);
      a = awvalid && awready;
      w = wvalid && wready;
      @(posedge aclk);
      if (a) awvalid <= 1'b0;
      if (w) wvalid <= 1'b0;
    end while (awvalid || wvalid);
    do @(negedge aclk); while (!bvalid);
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [9:0] i, input logic [15:0] e, input logic [1:0] r = 2'b00);
    qr.push_back({16'h0000, e});
    qs.push_back({30'h0, r});
    @(posedge aclk);
    araddr  <= {i, 2'b00};
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  // skip the first trigger after a change, then time the next one
  task automatic interval(input logic [31:0] e);
    @(negedge aclk iff trig);
    @(posedge aclk);
    qt.push_back(e);
    wait (qt.size() == 0);
  endtask

  task automatic final_report();
    $display("checked %0d, mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // answers are judged at the negedge before the handshake edge
  always @(negedge aclk) begin
    if (rvalid && rready) cmp(rdata, qr.pop_front());
    if (rvalid && rready) cmp({30'h0, rresp}, qs.pop_front());
    if (bvalid && bready) cmp({30'h0, bresp}, qb.pop_front());
    if (trig && qt.size() > 0) cmp(cyc - last, qt.pop_front());
    if (trig) last = cyc;
  end
  always @(posedge aclk) cyc <= cyc + 1;

  initial begin
    #(40 * 40000);
    error_cnt++;
    $display("watchdog expired");
    final_report();
  end

  initial begin
    aresetn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready, sleep} = 6'h00;
    {awaddr, araddr, wdata, wstrb} = {24'h0, 32'h0, 4'hf};
    {cken, lvl, half} = 16'h0003;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TMRP_IDX_B_LPER, 16'hffff);
    rd(`TMRP_IDX_B_HCON, 16'h0000);
    rd(10'h000, 16'h0000, `TMRP_RESP_SLVERR);
    wr(10'h000, 16'h1234, `TMRP_RESP_SLVERR);
    v = $random(seed);
    wr(`TMRP_IDX_B_HPER, v[15:0]);
    rd(`TMRP_IDX_B_HPER, v[15:0]);
    wr(`TMRP_IDX_A_HCON, v[15:0] & 16'h7fff);
    rd(`TMRP_IDX_A_HCON, v[15:0] & 16'h7fff & `TMRP_HCON_MASK);
    $display("registers done");
    wr(`TMRP_IDX_A_HPER, 16'h0003);
    for (k = 0; k < 4; k++) begin
      wr(`TMRP_IDX_A_HCON, {8'h80, 2'b00, k[1:0], 4'h0});
      interval(k == 3 ? 32'd1024 : 32'd4 << (3 * k));
    end
    $display("prescaler done");
    wr(`TMRP_IDX_A_LPER, 16'h0001);
    wr(`TMRP_IDX_A_HPER, 16'h0000);
    wr(`TMRP_IDX_A_LCON, 16'h8018);
    wr(`TMRP_IDX_A_HCON, 16'h8030);
    interval(32'd16);
    rd(`TMRP_IDX_IRQ_FLAG_STATUS_0, 16'h0080);
    @(negedge aclk);
    cmp({31'h0, irq_a}, 32'h0);
    wr(`TMRP_IDX_IRQ_ENABLE_CONTROL_0, 16'h0080);
    repeat (2) @(negedge aclk);
    cmp({31'h0, irq_a}, 32'h1);
    wr(`TMRP_IDX_A_LCON, 16'h0008);
    wr(`TMRP_IDX_IRQ_FLAG_STATUS_0, 16'h0000);
    rd(`TMRP_IDX_IRQ_FLAG_STATUS_0, 16'h0000);
    wr(`TMRP_IDX_IRQ_FLAG_STATUS_0, 16'h0100);
    repeat (2) @(negedge aclk);
    cmp({31'h0, irq_b}, 32'h0);
    wr(`TMRP_IDX_IRQ_ENABLE_CONTROL_0, 16'h0100);
    repeat (2) @(negedge aclk);
    cmp({31'h0, irq_b}, 32'h1);
    wr(`TMRP_IDX_IRQ_FLAG_STATUS_0, 16'h0000);
    $display("chained and interrupt done");
    wr(`TMRP_IDX_A_LPER, 16'hffff);
    wr(`TMRP_IDX_A_HOLD, 16'h0000);
    wr(`TMRP_IDX_A_LCNT, 16'h0000);
    wr(`TMRP_IDX_A_LCON, 16'h8048);
    lvl[0] <= 1'b1;
    repeat (10) @(posedge aclk);
    lvl[0] <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(`TMRP_IDX_A_LCNT, 16'h000a);
    rd(`TMRP_IDX_IRQ_FLAG_STATUS_0, 16'h0080);
    $display("gate done");
    wr(`TMRP_IDX_A_LCON, 16'h0008);
    wr(`TMRP_IDX_A_HOLD, 16'h1234);
    wr(`TMRP_IDX_A_LCNT, 16'h5678);
    rd(`TMRP_IDX_A_HCNT, 16'h1234);
    wr(`TMRP_IDX_A_HOLD, 16'h0000);
    rd(`TMRP_IDX_A_LCNT, 16'h5678);
    rd(`TMRP_IDX_A_HOLD, 16'h1234);
    wr(`TMRP_IDX_A_LCON, 16'h0018);
    rd(`TMRP_IDX_A_LCNT, 16'h5678);
    cmp({tb_hi, tb_lo}, 32'h1234_5678);
    wr(`TMRP_IDX_B_LCON, 16'h0008);
    wr(`TMRP_IDX_B_HOLD, 16'habcd);
    wr(`TMRP_IDX_B_LCNT, 16'h1111);
    rd(`TMRP_IDX_B_HCNT, 16'habcd);
    $display("coherent access done");
    wr(`TMRP_IDX_A_LCON, 16'h0000);
    wr(`TMRP_IDX_A_HPER, 16'h0001);
    wr(`TMRP_IDX_A_HCNT, 16'h0000);
    cken[1] <= 1'b1;
    wr(`TMRP_IDX_A_HCON, 16'h8002);
    interval(32'd12);
    cken[1] <= 1'b0;
    wr(`TMRP_IDX_A_HCON, 16'h0000);
    sleep <= 1'b1;
    wr(`TMRP_IDX_A_LCNT, 16'h0040);
    wr(`TMRP_IDX_A_LCON, 16'h8000);
    repeat (20) @(posedge aclk);
    rd(`TMRP_IDX_A_LCNT, 16'h0040);
    sleep <= 1'b0;
    $display("clock source and sleep done");
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule
`default_nettype wire
